//--- lfr_debounce.sv
`include "lfr_defines.svh"
module lfr_debounce
  import lfr_pkg::*;
#(
  parameter int unsigned CYC = `LFR_DEBOUNCE_CYC
)
(
  input  wire logic clock,    // system clock
  input  wire logic resetn,   // async reset, active low
  input  wire logic level_in, // synchronised pin level
  output logic      stable,   // debounced level
  output logic      press     // pulse on debounced fall
);
  localparam int unsigned            LASTI = CYC - 1;
  localparam logic [`LFR_DBNC_W-1:0] LAST  = LASTI[`LFR_DBNC_W-1:0];

  logic [`LFR_DBNC_W-1:0] cnt;
  wire logic differs = (level_in != stable);
  wire logic settle  = differs && (cnt == LAST);

  // both edges must hold for the full time before they count
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt    <= '0;
      stable <= 1'b1;
      press  <= 1'b0;
    end
    else
    begin
      cnt    <= (!differs || settle) ? '0 : cnt + 1'b1;
      stable <= settle ? level_in : stable;
      press  <= settle && !level_in;
    end
  end
endmodule : lfr_debounce

//--- lfr_defines.svh
`ifndef LFR_DEFINES_SVH
`define LFR_DEFINES_SVH

`define LFR_STEPS            63
`define LFR_IDX_W            6
`define LFR_IDX_MAX          6'h3E
`define LFR_LVL_W            10
`define LFR_FULL_SCALE       10'h3E8
`define LFR_SHORT_PCT        20
`define LFR_ROLL_PCT_PER_C   3
`define LFR_RTSET_W          20
`define LFR_ACC_W            32
`define LFR_DBNC_W           23
`define LFR_CLK_PERIOD_NS    5
`define LFR_FADE_NS_PER_OHM  2500
`define LFR_FADE_CYC_PER_OHM (`LFR_FADE_NS_PER_OHM / `LFR_CLK_PERIOD_NS)
`define LFR_INSTANT_NS       70000
`define LFR_INSTANT_CYC      (`LFR_INSTANT_NS / `LFR_CLK_PERIOD_NS)
`define LFR_DEBOUNCE_NS      37000000
`define LFR_DEBOUNCE_CYC     (`LFR_DEBOUNCE_NS / `LFR_CLK_PERIOD_NS)
`define LFR_SHORT_FILT_NS    10000
`define LFR_SHORT_FILT_CYC   ((`LFR_SHORT_FILT_NS + `LFR_CLK_PERIOD_NS - 1) / `LFR_CLK_PERIOD_NS)
`define LFR_NSYNC            9
`define LFR_SY_TOGGLE        0
`define LFR_SY_PWM           1
`define LFR_SY_UV45          2
`define LFR_SY_UV46          3
`define LFR_SY_UV38          4
`define LFR_SY_SHORT         5
`define LFR_SY_CURRENT_SET_RESISTOR_PIN          6
`define LFR_SY_T145          7
`define LFR_SY_T175          8

`endif

//--- lfr_fade_ctrl.sv
`include "lfr_defines.svh"
module lfr_fade_ctrl
  import lfr_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC    = `LFR_DEBOUNCE_CYC,
  parameter int unsigned INSTANT_CYC     = `LFR_INSTANT_CYC,
  parameter bit          PWM_ACTIVE_HIGH = 1'b1
)
(
  input  wire logic                   clock,                     // 200 MHz clock
  input  wire logic                   resetn,                    // async reset, low
  input  wire logic                   toggle_pin_n,              // switch, low = pressed
  input  wire logic                   pwm_pin,                   // external pwm
  input  wire logic                   supply_below_4v5,          // uv off comparator
  input  wire logic                   supply_above_4v6,          // uv on comparator
  input  wire logic                   supply_below_3v8,          // latch loss comparator
  input  wire logic                   below_short_detect_threshold, // out short comp
  input  wire logic                   current_set_resistor_pin_short, // set pin short
  input  wire logic                   die_above_145c,            // rollback comparator
  input  wire logic                   die_above_175c,            // shutdown comparator
  input  wire logic [5:0]             die_excess_deg,            // degrees above 145 C
  input  wire logic [`LFR_RTSET_W-1:0] fade_in_time_pin,         // ohms, 0 = grounded
  input  wire logic [`LFR_RTSET_W-1:0] fade_out_time_pin,        // ohms, 0 = grounded
  output logic      [`LFR_LVL_W-1:0]  current_level,             // permille of full scale
  output logic                        source_enable,             // current source on
  output logic                        channel_on,                // toggle latch
  output logic                        ramp_busy,                 // ramp in progress
  output logic                        pwm_active,                // pwm gating the source
  output logic                        short_foldback,            // 20 percent foldback
  output logic                        current_set_resistor_pin_clamp,                // set pin clamp active
  output logic                        thermal_shutdown           // shutdown latched
);
  localparam int                      AW         = `LFR_ACC_W;
  localparam logic [AW-1:0]           INST_T     = AW'(INSTANT_CYC);
  localparam logic [AW-1:0]           OHM_CYC    = AW'(`LFR_FADE_CYC_PER_OHM);
  localparam logic [AW-1:0]           STEP_INC   = AW'(`LFR_STEPS);
  localparam logic [11:0]             SHORT_LAST = 12'(`LFR_SHORT_FILT_CYC - 1);
  localparam logic [16:0]             PCT_DIV    = 17'h00064;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire logic [`LFR_NSYNC-1:0] pin_raw = {
    die_above_175c,
    die_above_145c,
    current_set_resistor_pin_short,
    below_short_detect_threshold,
    supply_below_3v8,
    supply_above_4v6,
    supply_below_4v5,
    pwm_pin,
    toggle_pin_n
  };

  logic [`LFR_NSYNC-1:0] sync_meta;
  logic [`LFR_NSYNC-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < `LFR_NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
        begin
          sync_meta[gi] <= (gi == `LFR_SY_TOGGLE);
          sync_q[gi]    <= (gi == `LFR_SY_TOGGLE);
        end
        else
        begin
          sync_meta[gi] <= pin_raw[gi];
          sync_q[gi]    <= sync_meta[gi];
        end
      end
    end
  endgenerate

  wire logic pwm_s   = sync_q[`LFR_SY_PWM];
  wire logic uv45_s  = sync_q[`LFR_SY_UV45];
  wire logic uv46_s  = sync_q[`LFR_SY_UV46];
  wire logic lo_rst  = sync_q[`LFR_SY_UV38];
  wire logic short_s = sync_q[`LFR_SY_SHORT];
  wire logic current_set_resistor_pin_s  = sync_q[`LFR_SY_CURRENT_SET_RESISTOR_PIN];
  wire logic t145_s  = sync_q[`LFR_SY_T145];
  wire logic t175_s  = sync_q[`LFR_SY_T175];

  ////////////////////////////////////////////////////////////////////////////////
  // toggle debounce and gamma table

  logic                   press;
  logic [`LFR_LVL_W-1:0]  gamma_q;
  logic [`LFR_IDX_W-1:0]  idx;

  // debounce is not bypassed in instant mode
  lfr_debounce #(
    .CYC      (DEBOUNCE_CYC)
  ) u_debounce (
    .clock    (clock),
    .resetn   (resetn),
    .level_in (sync_q[`LFR_SY_TOGGLE]),
    .stable   (),
    .press    (press)
  );

  lfr_gamma_rom u_gamma (
    .clock  (clock),
    .resetn (resetn),
    .addr   (idx),
    .data   (gamma_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // latch, protection state

  logic                   uv_off;
  logic                   tsd;
  logic [11:0]            short_cnt;
  logic                   short_q;
  lfr_ramp_t              ramp_state;
  lfr_ramp_t              next_ramp_state;
  logic [AW-1:0]          acc;

  wire logic shut        = lo_rst || tsd || t175_s;
  wire logic turn_on_req = press && !channel_on;
  wire logic blocked     = turn_on_req && (tsd || t175_s);
  wire logic flip        = press && !blocked && !lo_rst;
  wire logic next_channel_on = shut ? 1'b0 : (flip ? !channel_on : channel_on);

  // set wins over clear for both latches
  wire logic next_uv_off = uv45_s ? 1'b1 : (uv46_s ? 1'b0 : uv_off);
  wire logic next_tsd    = t175_s ? 1'b1 : (t145_s ? tsd : 1'b0);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_on <= 1'b0;
      uv_off     <= 1'b0;
      tsd        <= 1'b0;
    end
    else
    begin
      channel_on <= next_channel_on;
      uv_off     <= next_uv_off;
      tsd        <= next_tsd;
    end
  end

  wire logic short_hit = short_s && (short_cnt == SHORT_LAST);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      short_cnt <= '0;
      short_q   <= 1'b0;
    end
    else
    begin
      short_cnt <= (!short_s || short_hit) ? '0 : short_cnt + 1'b1;
      short_q   <= short_s && (short_q || short_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ramp step timing

  wire logic                    ramping  = (ramp_state != LFR_IDLE);
  wire logic [`LFR_RTSET_W-1:0] sel_r    = (ramp_state == LFR_UP) ? fade_in_time_pin
                                                                  : fade_out_time_pin;
  wire logic [AW-1:0]           target   = (sel_r == '0) ? INST_T
                                                         : AW'(sel_r) * OHM_CYC;
  wire logic [AW-1:0]           acc_sum  = acc + STEP_INC;
  wire logic                    step     = ramping && (acc_sum >= target);
  wire logic                    at_top   = (idx == `LFR_IDX_MAX);
  wire logic                    at_bot   = (idx == 6'h00);

  wire logic [AW-1:0] next_acc = (flip || !ramping) ? '0
                               : (step ? acc_sum - target : acc_sum);

  wire logic [`LFR_IDX_W-1:0] next_idx =
      shut                                          ? 6'h00 :
      (step && ramp_state == LFR_UP   && !at_top)   ? idx + 6'h01 :
      (step && ramp_state == LFR_DOWN && !at_bot)   ? idx - 6'h01 :
      idx;

  always_comb
  begin
    next_ramp_state = ramp_state;
    if (shut)
      next_ramp_state = LFR_IDLE;
    else if (flip)
      next_ramp_state = next_channel_on ? LFR_UP : LFR_DOWN;
    else
    begin
      unique case (ramp_state)
        LFR_IDLE: next_ramp_state = LFR_IDLE;
        LFR_UP:   next_ramp_state = at_top ? LFR_IDLE : LFR_UP;
        LFR_DOWN: next_ramp_state = at_bot ? LFR_IDLE : LFR_DOWN;
        default:  next_ramp_state = LFR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ramp_state <= LFR_IDLE;
      idx        <= 6'h00;
      acc        <= '0;
    end
    else
    begin
      ramp_state <= next_ramp_state;
      idx        <= next_idx;
      acc        <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output level

  wire logic pwm_level = PWM_ACTIVE_HIGH ? pwm_s : !pwm_s;
  wire logic pwm_mode  = !channel_on && at_bot && (ramp_state == LFR_IDLE);

  // pwm gates full scale directly, so average follows duty
  wire logic [`LFR_LVL_W-1:0] raw_level = pwm_mode ? (pwm_level ? `LFR_FULL_SCALE : 10'h000)
                                                   : gamma_q;

  wire logic [16:0] fold_prod  = 17'(raw_level) * 17'(`LFR_SHORT_PCT);
  wire logic [`LFR_LVL_W-1:0] fold_level = short_q ? 10'(fold_prod / PCT_DIV)
                                                   : raw_level;

  wire logic [7:0]  derate   = 8'(die_excess_deg) * 8'(`LFR_ROLL_PCT_PER_C);
  wire logic [6:0]  keep_pct = (derate >= 8'h64) ? 7'h00 : 7'(8'h64 - derate);
  wire logic [16:0] roll_prod = 17'(fold_level) * 17'(keep_pct);
  wire logic [`LFR_LVL_W-1:0] roll_level = t145_s ? 10'(roll_prod / PCT_DIV)
                                                  : fold_level;

  wire logic                  src_off    = uv_off || tsd;
  wire logic [`LFR_LVL_W-1:0] next_level = src_off ? 10'h000 : roll_level;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      current_level    <= 10'h000;
      source_enable    <= 1'b0;
      ramp_busy        <= 1'b0;
      pwm_active       <= 1'b0;
      short_foldback   <= 1'b0;
      current_set_resistor_pin_clamp       <= 1'b0;
      thermal_shutdown <= 1'b0;
    end
    else
    begin
      current_level    <= next_level;
      source_enable    <= !src_off;
      ramp_busy        <= (next_ramp_state != LFR_IDLE);
      pwm_active       <= pwm_mode;
      short_foldback   <= short_q;
      current_set_resistor_pin_clamp       <= current_set_resistor_pin_s;
      thermal_shutdown <= next_tsd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_IDX_RANGE: assert property (idx <= `LFR_IDX_MAX)
    else $error("step index beyond table end");

  AST_ONE_STEP: assert property ((idx != $past(idx)) && (idx != 6'h00) |->
    ((idx - $past(idx)) == 6'h01) || (($past(idx) - idx) == 6'h01))
    else $error("index moved more than one step");

  AST_UP_DIR: assert property (($past(ramp_state) == LFR_UP) && !$past(shut) &&
    (idx != $past(idx)) |-> idx == $past(idx) + 6'h01)
    else $error("up ramp did not climb by one");

  AST_HOLD_END: assert property ((ramp_state == LFR_IDLE) && !press && !shut |=>
    $stable(idx))
    else $error("idle index drifted");

  AST_TOGGLE_FLIP: assert property (press && !tsd && !t175_s && !lo_rst |=>
    channel_on != $past(channel_on))
    else $error("toggle did not flip channel");

  AST_TSD_BLOCK: assert property (tsd |=> !channel_on)
    else $error("channel on during thermal shutdown");

  AST_LATCH_LOSS: assert property (lo_rst |=> !channel_on && (idx == 6'h00))
    else $error("latch kept below 3.8 V");

  AST_UV_OFF: assert property (uv_off |=> !source_enable && (current_level == 10'h000))
    else $error("source on during undervoltage");

  AST_PWM_IGNORED: assert property ($past(channel_on) |-> !pwm_active)
    else $error("pwm gating while toggled on");

  AST_FOLDBACK: assert property (short_foldback |-> current_level <= 10'h0C8)
    else $error("short foldback above 20 percent");

  COV_RAMP_TOP: cover property ((ramp_state == LFR_UP) ##1 (idx == `LFR_IDX_MAX));
  COV_REVERSE: cover property ((ramp_state == LFR_UP) && flip && !at_bot);
  COV_PWM_FULL: cover property (pwm_active && (current_level == `LFR_FULL_SCALE));
  COV_TSD: cover property (thermal_shutdown && press);
endmodule : lfr_fade_ctrl

//--- lfr_gamma_rom.sv
`include "lfr_defines.svh"
module lfr_gamma_rom
  import lfr_pkg::*;
(
  input  wire logic                    clock,  // system clock
  input  wire logic                    resetn, // async reset, active low
  input  wire logic [`LFR_IDX_W-1:0]   addr,   // step index
  output logic      [`LFR_LVL_W-1:0]   data    // registered level
);
  localparam logic [`LFR_LVL_W-1:0] GAMMA [0:62] = '{
    10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00A, 10'h00C, 10'h010,
    10'h014, 10'h018, 10'h01C, 10'h020, 10'h024, 10'h02A, 10'h030, 10'h036,
    10'h03C, 10'h042, 10'h048, 10'h050, 10'h058, 10'h060, 10'h068, 10'h070,
    10'h078, 10'h082, 10'h08C, 10'h096, 10'h0A0, 10'h0AA, 10'h0B4, 10'h0C2,
    10'h0D0, 10'h0DE, 10'h0EC, 10'h0FA, 10'h108, 10'h11A, 10'h12C, 10'h13E,
    10'h150, 10'h162, 10'h174, 10'h18A, 10'h1A0, 10'h1B6, 10'h1CC, 10'h1E2,
    10'h1F8, 10'h216, 10'h234, 10'h252, 10'h270, 10'h28E, 10'h2AC, 10'h2D2,
    10'h2F8, 10'h31E, 10'h344, 10'h36A, 10'h392, 10'h3BC, 10'h3E8
  };

  wire logic [`LFR_IDX_W-1:0] safe_addr = (addr > `LFR_IDX_MAX) ? `LFR_IDX_MAX : addr;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      data <= 10'h000;
    else
      data <= GAMMA[safe_addr];
  end
endmodule : lfr_gamma_rom

//--- lfr_pkg.sv
`include "lfr_defines.svh"
package lfr_pkg;
  typedef enum logic [2:0]
  {
    LFR_IDLE = 3'h1,
    LFR_UP   = 3'h2,
    LFR_DOWN = 3'h4
  } lfr_ramp_t;
endpackage : lfr_pkg

//--- lfr_switch_model.sv
module lfr_switch_model
(
  input  wire logic clock,        // system clock
  output logic      toggle_pin_n, // switch contact, low = pressed
  output logic      pwm_pin       // external pwm source
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    toggle_pin_n <= 1'b1;
    pwm_pin      <= 1'b0;
  end

  // contact held for n clocks, then released for n clocks
  task automatic press(input int n);
    @(posedge clock);
    toggle_pin_n <= 1'b0;
    repeat (n) @(posedge clock);
    toggle_pin_n <= 1'b1;
    repeat (n) @(posedge clock);
  endtask : press

  task automatic set_pwm(input logic v);
    @(posedge clock);
    pwm_pin <= v;
  endtask : set_pwm
endmodule : lfr_switch_model

//--- testbench.sv
module testbench
  import lfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int G[63] = '{0,2,4,6,8,10,12,16,20,24,28,32,36,42,48,54,60,66,72,80,88,96,104,
    112,120,130,140,150,160,170,180,194,208,222,236,250,264,282,300,318,336,354,372,394,416,
    438,460,482,504,534,564,594,624,654,684,722,760,798,836,874,914,956,1000};
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        toggle_pin_n;
  logic        pwm_pin;
  logic        supply_below_4v5;
  logic        supply_above_4v6;
  logic        supply_below_3v8;
  logic        below_short_detect_threshold;
  logic        current_set_resistor_pin_short;
  logic        die_above_145c;
  logic        die_above_175c;
  logic [5:0]  die_excess_deg;
  logic [19:0] fade_in_time_pin;
  logic [19:0] fade_out_time_pin;
  logic [9:0]  current_level;
  logic [9:0]  level_n;
  logic        source_enable;
  logic        channel_on;
  logic        ramp_busy;
  logic        pwm_active;
  logic        short_foldback;
  logic        current_set_resistor_pin_clamp;
  logic        thermal_shutdown;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [9:0]  q[$];

  always #2.5 clock = ~clock;

  lfr_switch_model sw (.clock, .toggle_pin_n, .pwm_pin);

  lfr_fade_ctrl #(.DEBOUNCE_CYC(20), .INSTANT_CYC(126), .PWM_ACTIVE_HIGH(1'b1)) dut
  (
    .clock, .resetn, .toggle_pin_n, .pwm_pin, .supply_below_4v5, .supply_above_4v6,
    .supply_below_3v8, .below_short_detect_threshold, .current_set_resistor_pin_short,
    .die_above_145c, .die_above_175c, .die_excess_deg, .fade_in_time_pin,
    .fade_out_time_pin, .current_level, .source_enable, .channel_on, .ramp_busy,
    .pwm_active, .short_foldback, .current_set_resistor_pin_clamp, .thermal_shutdown
  );

  // second build with active-low pwm, exercises the polarity parameter
  lfr_fade_ctrl #(.DEBOUNCE_CYC(20), .INSTANT_CYC(126), .PWM_ACTIVE_HIGH(1'b0)) dut_n
  (
    .clock, .resetn, .toggle_pin_n, .pwm_pin, .supply_below_4v5, .supply_above_4v6,
    .supply_below_3v8, .below_short_detect_threshold, .current_set_resistor_pin_short,
    .die_above_145c, .die_above_175c, .die_excess_deg, .fade_in_time_pin,
    .fade_out_time_pin, .current_level(level_n), .source_enable(), .channel_on(),
    .ramp_busy(), .pwm_active(), .short_foldback(), .current_set_resistor_pin_clamp(), .thermal_shutdown()
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic tap;
    fork
      sw.press(30);
    join_none
  endtask : tap

  task automatic wait_on(input logic v);
    int i;
    i = 0;
    while (channel_on !== v && i < 200)
    begin
      cyc(1);
      i++;
    end
    chk("channel_on", v, channel_on);
  endtask : wait_on

  // distinct levels until the ramp has ended; dur = busy cycles
  task automatic watch(output int dur);
    int k;
    q = {current_level};
    dur = 0;
    k = 0;
    while (k < 4 && dur < 3000)
    begin
      cyc(1);
      dur++;
      if (current_level !== q[$])
        q.push_back(current_level);
      if (ramp_busy === 1'b0)
        k++;
    end
    dur = dur - 4;
  endtask : watch

  task automatic chk_seq(input bit up);
    int bad;
    bad = 0;
    foreach (q[i])
      if (q[i] !== 10'(G[up ? i : 62 - i]))
        bad++;
    chk("ramp_steps", 63, q.size());
    chk("gamma_mismatch", 0, bad);
  endtask : chk_seq

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_fade;
    int d;
    chk("off_at_power_up", 0, channel_on);
    tap();
    wait_on(1'b1);
    chk("busy_on_flip", 1, ramp_busy);
    watch(d);
    chk_seq(1'b1);
    chk("fade_in_len_ok", 1, d >= 488 && d <= 496);
    cyc(20);
    chk("level_held", 1000, current_level);
    tap();
    wait_on(1'b0);
    watch(d);
    chk_seq(1'b0);
    chk("fade_out_len_ok", 1, d >= 980 && d <= 988);
    $display("test fade done");
  endtask : t_fade

  task automatic t_interrupt;
    int i, k, l, d;
    i = 0;
    k = 1;
    tap();
    wait_on(1'b1);
    while (current_level < 88 && i < 1000)
    begin
      cyc(1);
      i++;
    end
    tap();
    wait_on(1'b0);
    cyc(3);
    l = current_level;
    chk("mid_ramp_level", 1, l > 80 && l < 1000);
    for (int j = 1; j < 63; j++)
      if (G[j] == l)
        k = j;
    i = 0;
    while (current_level == l && i < 100)
    begin
      cyc(1);
      i++;
    end
    chk("reverse_step", G[k-1], current_level);
    watch(d);
    chk("down_to_zero", 0, current_level);
    $display("test interrupt done");
  endtask : t_interrupt

  task automatic t_instant;
    int d;
    @(posedge clock);
    fade_in_time_pin  <= 20'h00000;
    fade_out_time_pin <= 20'h00000;
    sw.press(10);
    cyc(40);
    chk("glitch_no_flip", 0, channel_on);
    tap();
    wait_on(1'b1);
    watch(d);
    chk("instant_len_ok", 1, d >= 120 && d <= 128);
    chk("instant_level", 1000, current_level);
    tap();
    wait_on(1'b0);
    watch(d);
    chk("instant_off_len_ok", 1, d >= 120 && d <= 128);
    chk("instant_off_level", 0, current_level);
    @(posedge clock);
    fade_in_time_pin  <= 20'h00001;
    fade_out_time_pin <= 20'h00002;
    $display("test instant done");
  endtask : t_instant

  task automatic t_pwm;
    int d;
    sw.set_pwm(1'b1);
    cyc(4);
    chk("pwm_high_level", 1000, current_level);
    chk("pwm_high_inverted", 0, level_n);
    chk("pwm_active", 1, pwm_active);
    sw.set_pwm(1'b0);
    cyc(4);
    chk("pwm_low_level", 0, current_level);
    chk("pwm_low_inverted", 1000, level_n);
    sw.set_pwm(1'b1);
    cyc(4);
    tap();
    wait_on(1'b1);
    sw.set_pwm(1'b0);
    watch(d);
    chk("pwm_ignored", 1000, current_level);
    chk("pwm_inactive", 0, pwm_active);
    tap();
    wait_on(1'b0);
    watch(d);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_supply;
    int d;
    tap();
    wait_on(1'b1);
    watch(d);
    @(posedge clock);
    supply_below_4v5 <= 1'b1;
    supply_above_4v6 <= 1'b0;
    cyc(5);
    chk("uv_source_off", 0, source_enable);
    chk("uv_level", 0, current_level);
    chk("uv_latch_kept", 1, channel_on);
    @(posedge clock);
    supply_below_4v5 <= 1'b0;
    cyc(5);
    chk("uv_hysteresis", 0, source_enable);
    @(posedge clock);
    supply_above_4v6 <= 1'b1;
    cyc(5);
    chk("uv_recover", 1, source_enable);
    chk("uv_level_back", 1000, current_level);
    @(posedge clock);
    supply_below_3v8 <= 1'b1;
    cyc(5);
    chk("latch_lost", 0, channel_on);
    @(posedge clock);
    supply_below_3v8 <= 1'b0;
    cyc(100);
    $display("test supply done");
  endtask : t_supply

  task automatic t_fault;
    int d;
    tap();
    wait_on(1'b1);
    watch(d);
    @(posedge clock);
    below_short_detect_threshold <= 1'b1;
    cyc(1990);
    chk("short_filtered", 0, short_foldback);
    cyc(20);
    chk("short_fold", 1, short_foldback);
    chk("short_level", 200, current_level);
    @(posedge clock);
    below_short_detect_threshold <= 1'b0;
    cyc(6);
    chk("short_restore", 1000, current_level);
    @(posedge clock);
    current_set_resistor_pin_short <= 1'b1;
    cyc(5);
    chk("current_set_resistor_pin_clamp", 1, current_set_resistor_pin_clamp);
    @(posedge clock);
    current_set_resistor_pin_short <= 1'b0;
    cyc(5);
    chk("current_set_resistor_pin_release", 0, current_set_resistor_pin_clamp);
    @(posedge clock);
    die_excess_deg <= 6'h0A;
    die_above_145c <= 1'b1;
    cyc(6);
    chk("rollback_level", 700, current_level);
    @(posedge clock);
    die_above_175c <= 1'b1;
    cyc(5);
    chk("tsd_flag", 1, thermal_shutdown);
    chk("tsd_off", 0, channel_on);
    @(posedge clock);
    die_above_175c <= 1'b0;
    tap();
    cyc(70);
    chk("tsd_blocks_press", 0, channel_on);
    @(posedge clock);
    die_above_145c <= 1'b0;
    cyc(5);
    chk("tsd_cleared", 0, thermal_shutdown);
    tap();
    wait_on(1'b1);
    watch(d);
    $display("test fault done");
  endtask : t_fault

  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clock);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    supply_below_4v5               <= 1'b0;
    supply_above_4v6               <= 1'b1;
    supply_below_3v8               <= 1'b0;
    below_short_detect_threshold   <= 1'b0;
    current_set_resistor_pin_short <= 1'b0;
    die_above_145c                 <= 1'b0;
    die_above_175c                 <= 1'b0;
    die_excess_deg                 <= 6'h00;
    fade_in_time_pin               <= 20'h00001;
    fade_out_time_pin              <= 20'h00002;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    cyc(5);
    chk("source_after_reset", 1, source_enable);
    chk("level_after_reset", 0, current_level);
    t_fade();
    t_interrupt();
    t_instant();
    t_pwm();
    t_supply();
    t_fault();
    give_verdict();
  end
endmodule : testbench
